// >>> design/interval_timer_params.svh
`ifndef INTERVAL_TIMER_PARAMS_SVH
`define INTERVAL_TIMER_PARAMS_SVH
// register byte offsets
`define OFS_CMD 12'h000
`define OFS_SETV 12'h004
`define OFS_IVAL 12'h008
`define OFS_SUBR 12'h00c
`define OFS_RD_COUNT 12'h010
`define OFS_RD_IVAL 12'h014
`define OFS_RD_ELAPSED 12'h018
`define OFS_STATUS 12'h01c
`define OFS_IMASK 12'h020
`define OFS_PENDING 12'h024
`define OFS_GMASK 12'h028
`define OFS_RUNNING 12'h02c
`define OFS_SUBR0 12'h030
// command word fields
`define CMD_CODE_LSB 0
`define CMD_CONST_BIT 12
// instruction control codes (bcd)
`define CC_ONESHOT 12'h000
`define CC_SCHED 12'h003
`define CC_READ 12'h006
`define CC_STOP 12'h010
`define CC_GMASK 12'h100
`define CC_GUNMASK 12'h200
// operand limits (bcd)
`define IVAL_MIN 16'h0005
`define IVAL_MAX 16'h0320
`define IVAL_CONST 16'h0010
`define SUBR_MAX 16'h0255
// timing: base tick in ns and clock period in ns
`define TICK_NS 100000
`define CLK_NS 100
`define TICK_CYC (`TICK_NS / `CLK_NS)
// reset values
`define IMASK_RST 3'h7
`endif

// >>> design/interval_timer_pkg.sv
package interval_timer_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ONESHOT = 3'b010,
    ST_SCHED = 3'b100
  } tmode_t;
  typedef struct packed {
    tmode_t mode;
    logic [15:0] setv;
    logic [15:0] ival;
    logic [15:0] pv;
    logic [15:0] done;
    logic [15:0] sub;
    logic [15:0] elapsed;
  } chan_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage

// >>> design/interval_timer_interrupts.sv
// The address map and register access over APB were left to the implementer.
`include "interval_timer_params.svh"

// Overview of operation
// [R1] code 100 applies a group mask over every interrupt source
// [R2] code 200 removes the group mask so interrupts are serviced again
// [R3] group mask sits over individual masks, which are kept untouched
// [R4] interrupts during group mask stay pending and fire after unmask
// [R5] program must not mask or unmask the group from an interrupt routine
// [R6] three independent timers selected by codes 000, 001, 002
// [R7] program must not use timer 0 while pulse speed output runs
// [R8] program must not use timer 2 while fast counter setup word is nonzero
// [R9] one-shot: decrement per interval, call subroutine once at zero, stop
// [R10] set value is four bcd digits 0000 to 9999
// [R11] interval is bcd 0005 to 0320 in 0.1 ms units
// [R12] subroutine number is bcd 0000 to 0255, or 0127 on reduced parts
// [R13] constant set value uses a fixed interval of 10 (1 ms)
// [R14] scheduled: reload after each call and repeat until stopped
// [R15] elapsed read gives decrements, interval and time since last decrement
// [R16] elapsed read of a stopped timer returns 0000
// [R17] code timer number plus 10 stops that timer
// [R18] a prescaler makes the 0.1 ms tick that all timers count on
module interval_timer_interrupts #(
  parameter int NUM_TIMERS = 3,
  parameter int TICK_CYCLES = `TICK_CYC,
  parameter logic [15:0] SUBR_LIMIT = `SUBR_MAX
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt output and subroutine call strobe
  output logic irq,
  output logic call_valid,
  output logic [15:0] call_subr
);

  // =====================================================
  // state
  typedef struct packed {
    interval_timer_pkg::chan_t [2:0] ch;
    logic [15:0] presc;
    logic [15:0] setv_w;
    logic [15:0] ival_w;
    logic [15:0] subr_w;
    logic [15:0] rd_count;
    logic [15:0] rd_ival;
    logic [15:0] rd_elapsed;
    logic [2:0] status;
    logic [2:0] imask;
    logic gmask;
    logic [31:0] prdata;
    logic call_valid;
    logic [15:0] call_subr;
  } state_t;

  state_t q, d;
  interval_timer_pkg::apb_req_t req;
  logic tick;
  logic wr;
  logic [2:0] expire;

  assign req = '{psel, penable, pwrite, paddr, pwdata};
  assign wr = req.psel && req.penable && req.pwrite;

  // bcd helpers
  function automatic logic bcd_ok(input logic [15:0] v);
    bcd_ok = (v[3:0] < 4'ha) && (v[7:4] < 4'ha) && (v[11:8] < 4'ha) && (v[15:12] < 4'ha);
  endfunction

  function automatic logic [15:0] bcd_dec(input logic [15:0] v);
    logic [15:0] r;
    int i;
    logic borrow;
    r = v;
    borrow = 1'b1;
    for (i = 0; i < 4; i++) begin
      if (borrow) begin
        if (r[i*4 +: 4] == 4'h0) begin
          r[i*4 +: 4] = 4'h9;
        end else begin
          r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
          borrow = 1'b0;
        end
      end
    end
    bcd_dec = r;
  endfunction

  function automatic logic [15:0] bcd_inc(input logic [15:0] v);
    logic [15:0] r;
    int i;
    logic carry;
    r = v;
    carry = 1'b1;
    for (i = 0; i < 4; i++) begin
      if (carry) begin
        if (r[i*4 +: 4] == 4'h9) begin
          r[i*4 +: 4] = 4'h0;
        end else begin
          r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
          carry = 1'b0;
        end
      end
    end
    bcd_inc = r;
  endfunction

  // =====================================================
  // prescaler tick
  assign tick = (q.presc == 16'(TICK_CYCLES - 1)); // [R18]

  // =====================================================
  // next state
  always_comb begin
    logic [11:0] code;
    logic use_const;
    logic [1:0] sel;
    logic [15:0] sv;
    logic [15:0] iv;
    logic [2:0] fire;
    logic gm_set;
    d = q;
    code = req.pwdata[`CMD_CODE_LSB +: 12];
    use_const = req.pwdata[`CMD_CONST_BIT];
    sel = code[1:0];
    sv = q.setv_w;
    iv = q.ival_w;
    // a group mask written this cycle already holds back dispatch
    gm_set = wr && req.paddr == `OFS_CMD && code == `CC_GMASK;
    fire = 3'h0;
    expire = 3'h0;
    d.call_valid = 1'b0;
    d.presc = tick ? 16'h0 : q.presc + 16'h1;
    // per-timer counting on tick
    for (int t = 0; t < NUM_TIMERS; t++) begin
      if (tick && q.ch[t].mode != interval_timer_pkg::ST_IDLE) begin
        if (bcd_inc(q.ch[t].elapsed) == q.ch[t].ival) begin
          d.ch[t].elapsed = 16'h0;
          d.ch[t].done = bcd_inc(q.ch[t].done);
          if (q.ch[t].pv == 16'h0001 || q.ch[t].pv == 16'h0000) begin
            expire[t] = 1'b1;
            if (q.ch[t].mode == interval_timer_pkg::ST_SCHED) begin
              d.ch[t].pv = q.ch[t].setv; // [R14]
              d.ch[t].done = 16'h0;
            end else begin
              d.ch[t].mode = interval_timer_pkg::ST_IDLE; // [R9]
              d.ch[t].pv = 16'h0;
            end
          end else begin
            d.ch[t].pv = bcd_dec(q.ch[t].pv); // [R9]
          end
        end else begin
          d.ch[t].elapsed = bcd_inc(q.ch[t].elapsed);
        end
      end
    end
    // status bits: set wins over write-one-to-clear
    d.status = q.status;
    if (wr && req.paddr == `OFS_STATUS) begin
      d.status = q.status & ~req.pwdata[2:0];
    end
    d.status = d.status | expire; // [R4]
    // deliver one pending call when neither masked
    for (int t = NUM_TIMERS - 1; t >= 0; t--) begin
      if (q.status[t] && !q.imask[t] && !q.gmask && !gm_set) begin // [R3] [R1]
        fire = 3'h0;
        fire[t] = 1'b1;
      end
    end
    for (int t = 0; t < NUM_TIMERS; t++) begin
      if (fire[t] && !d.call_valid) begin
        d.call_valid = 1'b1;
        d.call_subr = q.ch[t].sub;
        d.status[t] = expire[t]; // [R4]
      end
    end
    // register writes
    if (wr) begin
      case (req.paddr)
        `OFS_SETV: d.setv_w = req.pwdata[15:0];
        `OFS_IVAL: d.ival_w = req.pwdata[15:0];
        `OFS_SUBR: d.subr_w = req.pwdata[15:0];
        `OFS_IMASK: d.imask = req.pwdata[2:0];
        `OFS_CMD: begin
          sv = use_const ? q.setv_w : q.setv_w;
          iv = use_const ? `IVAL_CONST : q.ival_w; // [R13]
          if (code == `CC_GMASK) begin
            d.gmask = 1'b1; // [R1]
          end else if (code == `CC_GUNMASK) begin
            d.gmask = 1'b0; // [R2]
          end else if ((code & 12'hffc) == `CC_STOP && sel < 2'd3) begin
            d.ch[sel].mode = interval_timer_pkg::ST_IDLE; // [R17]
          end else if ((code >= `CC_READ) && (code <= `CC_READ + 12'h002)) begin
            for (int t = 0; t < NUM_TIMERS; t++) begin
              if (code[3:0] == 4'(6 + t)) begin
                if (q.ch[t].mode == interval_timer_pkg::ST_IDLE) begin
                  d.rd_count = 16'h0; // [R16]
                  d.rd_ival = 16'h0;
                  d.rd_elapsed = 16'h0;
                end else begin
                  d.rd_count = q.ch[t].done; // [R15]
                  d.rd_ival = q.ch[t].ival;
                  d.rd_elapsed = q.ch[t].elapsed;
                end
              end
            end
          end else if (code[11:4] == 8'h0 && code[3:0] <= 4'h5) begin
            // start codes 000-002 one-shot, 003-005 scheduled
            for (int t = 0; t < NUM_TIMERS; t++) begin
              if (code[3:0] == 4'(t) || code[3:0] == 4'(3 + t)) begin // [R6]
                if (bcd_ok(sv) && bcd_ok(iv) && iv >= `IVAL_MIN && iv <= `IVAL_MAX
                    && bcd_ok(q.subr_w) && q.subr_w <= SUBR_LIMIT) begin // [R10] [R11] [R12]
                  d.ch[t].mode = (code[3:0] >= 4'h3) ? interval_timer_pkg::ST_SCHED
                                                     : interval_timer_pkg::ST_ONESHOT;
                  d.ch[t].setv = sv;
                  d.ch[t].pv = sv;
                  d.ch[t].ival = iv;
                  d.ch[t].sub = q.subr_w;
                  d.ch[t].done = 16'h0;
                  d.ch[t].elapsed = 16'h0;
                end
              end
            end
          end
        end
        default: ;
      endcase
    end
    // read data
    d.prdata = 32'h0;
    if (req.psel && !req.penable && !req.pwrite) begin
      case (req.paddr)
        `OFS_SETV: d.prdata = {16'h0, q.setv_w};
        `OFS_IVAL: d.prdata = {16'h0, q.ival_w};
        `OFS_SUBR: d.prdata = {16'h0, q.subr_w};
        `OFS_RD_COUNT: d.prdata = {16'h0, q.rd_count};
        `OFS_RD_IVAL: d.prdata = {16'h0, q.rd_ival};
        `OFS_RD_ELAPSED: d.prdata = {16'h0, q.rd_elapsed};
        `OFS_STATUS: d.prdata = {29'h0, q.status};
        `OFS_IMASK: d.prdata = {29'h0, q.imask};
        `OFS_PENDING: d.prdata = {29'h0, q.status & ~q.imask};
        `OFS_GMASK: d.prdata = {31'h0, q.gmask};
        `OFS_RUNNING: d.prdata = {29'h0, q.ch[2].mode != interval_timer_pkg::ST_IDLE,
                                  q.ch[1].mode != interval_timer_pkg::ST_IDLE,
                                  q.ch[0].mode != interval_timer_pkg::ST_IDLE};
        default: d.prdata = 32'h0;
      endcase
    end else if (req.psel && req.penable) begin
      d.prdata = q.prdata;
    end
  end

  // =====================================================
  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
      q.ch[0].mode <= interval_timer_pkg::ST_IDLE;
      q.ch[1].mode <= interval_timer_pkg::ST_IDLE;
      q.ch[2].mode <= interval_timer_pkg::ST_IDLE;
      q.imask <= `IMASK_RST;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // =====================================================
  // outputs
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = q.prdata;
  assign irq = |(q.status & ~q.imask) && !q.gmask; // [R3]
  assign call_valid = q.call_valid;
  assign call_subr = q.call_subr;

  // =====================================================
  // assertions
  property p_gmask_blocks;
    @(posedge clk) disable iff (reset) q.gmask |-> !irq && !call_valid;
  endproperty
  a_gmask_blocks: assert property (p_gmask_blocks) else $error("irq under group mask"); // [R1]

  property p_unmask;
    @(posedge clk) disable iff (reset)
      (clk_en && wr && req.paddr == `OFS_CMD && req.pwdata[11:0] == `CC_GUNMASK) |=> !q.gmask;
  endproperty
  a_unmask: assert property (p_unmask) else $error("unmask not taken"); // [R2]

  property p_mask_set;
    @(posedge clk) disable iff (reset)
      (clk_en && wr && req.paddr == `OFS_CMD && req.pwdata[11:0] == `CC_GMASK) |=> q.gmask;
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("group mask not taken"); // [R1]

  property p_imask_kept;
    @(posedge clk) disable iff (reset)
      (clk_en && wr && req.paddr == `OFS_CMD && req.pwdata[11:0] == `CC_GUNMASK)
      |=> q.imask == $past(q.imask);
  endproperty
  a_imask_kept: assert property (p_imask_kept) else $error("individual mask changed"); // [R3]

  property p_pending_kept;
    @(posedge clk) disable iff (reset)
      (clk_en && q.gmask && expire[1]) |=> q.status[1];
  endproperty
  a_pending_kept: assert property (p_pending_kept) else $error("pending lost"); // [R4]

  property p_oneshot_stops;
    @(posedge clk) disable iff (reset)
      (clk_en && expire[1] && q.ch[1].mode == interval_timer_pkg::ST_ONESHOT)
      |=> q.ch[1].mode == interval_timer_pkg::ST_IDLE;
  endproperty
  a_oneshot_stops: assert property (p_oneshot_stops) else $error("one-shot kept running"); // [R9]

  property p_sched_reload;
    @(posedge clk) disable iff (reset)
      (clk_en && expire[2] && q.ch[2].mode == interval_timer_pkg::ST_SCHED)
      |=> q.ch[2].pv == q.ch[2].setv && q.ch[2].mode == interval_timer_pkg::ST_SCHED;
  endproperty
  a_sched_reload: assert property (p_sched_reload) else $error("no reload"); // [R14]

  property p_tick_period;
    @(posedge clk) disable iff (reset) (clk_en && tick) |=> !tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick too often"); // [R18]

  property p_ival_range;
    @(posedge clk) disable iff (reset)
      q.ch[2].mode != interval_timer_pkg::ST_IDLE
      |-> q.ch[2].ival >= `IVAL_MIN && q.ch[2].ival <= `IVAL_MAX;
  endproperty
  a_ival_range: assert property (p_ival_range) else $error("interval out of range"); // [R11]

endmodule

// >>> dv/interval_timer_interrupts_test.sv
`include "interval_timer_params.svh"

module interval_timer_interrupts_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 4;
  logic clk, reset, clk_en, psel, penable, pwrite, pready, pslverr, irq, call_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] call_subr;
  logic [15:0] bad_sv [4] = '{16'h000a, 16'h0001, 16'h0001, 16'h0001};
  logic [15:0] bad_iv [4] = '{16'h0005, 16'h0004, 16'h0321, 16'h0005};
  logic [15:0] bad_sb [4] = '{16'h0001, 16'h0001, 16'h0001, 16'h0256};
  int err_count, num_checks, n, m;

  interval_timer_interrupts #(.TICK_CYCLES(TK)) interval_timer_interrupts_inst (
    .clk(clk), .reset(reset), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .call_valid(call_valid), .call_subr(call_subr));

  // ==========================================
  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================
  // checking and bus tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer: setup, then access until pready at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  // counts edges until a call strobe, stops at lim
  task automatic wait_call(input int lim, output int cyc);
    cyc = 0;
    do begin
      @(posedge clk);
      cyc++;
    end while (call_valid !== 1'b1 && cyc < lim);
  endtask

  // loads set value, interval, subroutine, then issues the command
  task automatic start(input logic [15:0] sv, iv, sb, input logic [31:0] cmd);
    wr(`OFS_SETV, {16'h0, sv});
    wr(`OFS_IVAL, {16'h0, iv});
    wr(`OFS_SUBR, {16'h0, sb});
    wr(`OFS_CMD, cmd);
  endtask

  // expiry lands within one tick of ticks*TK, plus two cycles for status and dispatch
  function automatic logic in_win(input int cyc, input int ticks);
    return (cyc >= (ticks - 1) * TK) && (cyc <= ticks * TK + 2);
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================
  // watchdog
  initial begin
    #3000000;
    err_count++;
    final_report();
  end

  // ==========================================
  // test sequence
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    err_count = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rdc("imask_rst", `OFS_IMASK, 32'h7);
    rdc("gmask_rst", `OFS_GMASK, 32'h0);
    rdc("unmapped", 12'h100, 32'h0);
    chk("bus_resp", {pready, pslverr}, 2'b10);
    // refused starts: bad bcd, interval out of range, subroutine too high
    for (int i = 0; i < 4; i++) begin
      start(bad_sv[i], bad_iv[i], bad_sb[i], 32'h0);
      rdc("bad_start", `OFS_RUNNING, 32'h0);
    end
    // one-shot timer 0 at the shortest interval
    wr(`OFS_IMASK, 32'h6);
    start(16'h0002, 16'h0005, 16'h0042, 32'h0); // no pulse output runs in the bench
    wait_call(200, n);
    chk("oneshot_time", in_win(n, 10), 1'b1);
    chk("oneshot_subr", call_subr, 16'h0042);
    rdc("oneshot_stop", `OFS_RUNNING, 32'h0);
    wait_call(100, n);
    chk("oneshot_once", n, 100);
    // constant set value on timer 0: fixed interval of 10
    start(16'h0002, 16'h0005, 16'h0043, 32'h1000);
    wait_call(200, n);
    chk("const_time", in_win(n, 20), 1'b1);
    // scheduled timer 2 at the longest interval, top subroutine number
    wr(`OFS_IMASK, 32'h2);
    start(16'h0001, 16'h0320, 16'h0255, 32'h005); // fast counter left unused
    wait_call(2000, n);
    chk("sched_subr", call_subr, 16'h0255);
    wait_call(2000, m);
    chk("sched_period", m, 1280);
    wr(`OFS_CMD, 32'h008);
    rdc("elapsed_ival", `OFS_RD_IVAL, 32'h0320);
    wr(`OFS_CMD, 32'h012);
    rdc("stopped", `OFS_RUNNING, 32'h0);
    wr(`OFS_CMD, 32'h008);
    rdc("stop_count", `OFS_RD_COUNT, 32'h0);
    rdc("stop_ival", `OFS_RD_IVAL, 32'h0);
    rdc("stop_elapsed", `OFS_RD_ELAPSED, 32'h0);
    // group mask holds timer 1 pending until unmask
    wr(`OFS_IMASK, 32'h0);
    wr(`OFS_CMD, 32'h100); // mask from main sequence, paired with unmask
    rdc("gmask_on", `OFS_GMASK, 32'h1);
    start(16'h0001, 16'h0005, 16'h0011, 32'h001);
    wait_call(60, n);
    chk("gmask_block", n, 60);
    chk("gmask_irq", irq, 1'b0);
    rdc("gmask_pend", `OFS_PENDING, 32'h2);
    rdc("gmask_imask", `OFS_IMASK, 32'h0);
    wr(`OFS_CMD, 32'h200); // unmask closes the pair
    @(posedge clk);
    chk("unmask_irq", irq, 1'b1);
    wait_call(5, n);
    chk("unmask_subr", call_subr, 16'h0011);
    // individual mask keeps the event in status, cleared by writing one
    wr(`OFS_IMASK, 32'h7);
    start(16'h0001, 16'h0005, 16'h0012, 32'h0);
    wait_call(60, n);
    chk("imask_block", n, 60);
    chk("imask_irq", irq, 1'b0);
    rdc("imask_status", `OFS_STATUS, 32'h1);
    wr(`OFS_STATUS, 32'h1);
    rdc("w1c_status", `OFS_STATUS, 32'h0);
    wr(`OFS_IMASK, 32'h6);
    wait_call(20, n);
    chk("w1c_nocall", n, 20);
    // clock enable low freezes a running one-shot, which resumes afterwards
    start(16'h0001, 16'h0005, 16'h0044, 32'h0);
    clk_en <= 1'b0;
    wait_call(60, n);
    chk("frozen", n, 60);
    clk_en <= 1'b1;
    wait_call(60, n);
    chk("thawed_time", n < 60, 1'b1);
    chk("thawed_subr", call_subr, 16'h0044);
    final_report();
  end
endmodule
